//--- verilog/selc_pkg.sv
package selc_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int FBDIV_W = 7;
   localparam int PREDIV_W = 2;
   localparam int RATE_W = 2;
   localparam int PER_W = 12;
   localparam int GOOD_W = 5;
   localparam int EV_W = 2;

   localparam logic [ADDR_W-1:0] FBDIV_OFS = 16'hf000;
   localparam logic [ADDR_W-1:0] PREDIV_OFS = 16'hf001;
   localparam logic [ADDR_W-1:0] SRC_OFS = 16'hf002;
   localparam logic [ADDR_W-1:0] RUN_OFS = 16'hf003;
   localparam logic [ADDR_W-1:0] LOCK_OFS = 16'hf004;
   localparam logic [ADDR_W-1:0] CLOCK_OUT_PIN_OFS = 16'hf005;
   localparam logic [ADDR_W-1:0] IRQ_STS_OFS = 16'hf00a;
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 16'hf00b;

   localparam int RUN_BIT = 0;
   localparam int LOCK_BIT = 0;
   localparam int SRC_BIT = 0;
   localparam int OUT_EN_BIT = 0;
   localparam int RATE_LSB = 1;
   localparam int EV_LOCK_BIT = 0;
   localparam int EV_UNLOCK_BIT = 1;

   localparam logic [FBDIV_W-1:0] FBDIV_RST = 7'h60;
   localparam logic [PREDIV_W-1:0] PREDIV_RST = 2'h0;
   localparam logic [RATE_W-1:0] RATE_RST = 2'h0;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

   localparam int CLK_PERIOD_PS = 4000;
   localparam int REF_TIMEOUT_NS = 2000;
   localparam int REF_TIMEOUT_CYC = (REF_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
   localparam int LOCK_PERIODS = 16;

   typedef enum logic [1:0] {
      SELC_IDLE = 2'b00,
      SELC_ACQ = 2'b01,
      SELC_LOCKED = 2'b10
   } selc_state_e;
endpackage : selc_pkg

//--- verilog/selc_synth_ctrl.sv
// Functional notes
// - No lock attempt until run bit set
// - Run bit low: no synth clock, downstream idle
// - Run rising edge activates all pending settings
// - Clock-out writes wait for next run edge
// - Lock flag read-only bit 0, cleared at reset
// - Lock needs reference, valid settings, run, settling
// - Rate code selects 1x/2x/4x/8x predivider output
// - Nominal rates 3.072 to 24.576 MHz ascending
// - Output enable drives pin, else high impedance
// - Run, lock, clock-out registers reset to zero
// - Prescaler divides reference by 1/2/4/8
// - Source select routes reference or synth clock
//
// Chosen here: the plain strobed port.
module selc_synth_ctrl
   import selc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [DATA_W-1:0] rdata,
   input wire logic reference_clock_input,
   output logic clock_out_pin,
   output logic clock_out_pin_oe,
   output logic synth_clk_valid,
   output logic core_clock_source_sel,
   output logic [FBDIV_W-1:0] feedback_divider_act,
   output logic [PREDIV_W-1:0] prescale_divider_act,
   output logic irq
);
   // Pending (software) copies
   logic [FBDIV_W-1:0] fbdiv_q, fbdiv_d;
   logic [PREDIV_W-1:0] prediv_q, prediv_d;
   logic src_q, src_d;
   logic run_q, run_d;
   logic run_prev_q, run_prev_d;
   logic [RATE_W-1:0] rate_q, rate_d;
   logic out_en_q, out_en_d;
   // Active copies
   logic [FBDIV_W-1:0] act_fbdiv_q, act_fbdiv_d;
   logic [PREDIV_W-1:0] act_prediv_q, act_prediv_d;
   logic act_src_q, act_src_d;
   logic [RATE_W-1:0] act_rate_q, act_rate_d;
   logic act_out_en_q, act_out_en_d;
   // Interrupt
   logic [EV_W-1:0] sts_q, sts_d;
   logic [EV_W-1:0] mask_q, mask_d;
   logic irq_q, irq_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   // Lock tracking
   logic ref_s1_q, ref_s2_q, ref_s3_q;
   logic [2:0] pre_cnt_q, pre_cnt_d;
   logic [PER_W-1:0] per_cnt_q, per_cnt_d;
   logic [PER_W-1:0] per_q, per_d;
   logic [GOOD_W-1:0] good_q, good_d;
   selc_state_e state_q, state_d;
   logic valid_q, valid_d;
   // Clock out
   logic [PER_W-1:0] oc_cnt_q, oc_cnt_d;
   logic out_q, out_d;
   logic oe_q, oe_d;

   logic run_rise;
   logic ref_rise;
   logic pre_tick;
   logic timeout;
   logic [2:0] pre_max;
   logic [PER_W-1:0] half;
   logic [EV_W-1:0] ev;

   localparam logic [PER_W-1:0] TIMEOUT_C = PER_W'(REF_TIMEOUT_CYC);
   localparam logic [GOOD_W-1:0] GOOD_LAST = GOOD_W'(LOCK_PERIODS - 1);

   // Register file and activation
   always_comb begin
      fbdiv_d = fbdiv_q;
      prediv_d = prediv_q;
      src_d = src_q;
      run_d = run_q;
      rate_d = rate_q;
      out_en_d = out_en_q;
      mask_d = mask_q;
      run_prev_d = run_q;
      run_rise = run_q & ~run_prev_q;
      act_fbdiv_d = act_fbdiv_q;
      act_prediv_d = act_prediv_q;
      act_src_d = act_src_q;
      act_rate_d = act_rate_q;
      act_out_en_d = act_out_en_q;
      if (run_rise) begin
         act_fbdiv_d = fbdiv_q;
         act_prediv_d = prediv_q;
         act_src_d = src_q;
         act_rate_d = rate_q;
         act_out_en_d = out_en_q;
      end
      sts_d = sts_q;
      if (wr_stb) begin
         if (addr == FBDIV_OFS) begin
            fbdiv_d = wdata[FBDIV_W-1:0];
         end else if (addr == PREDIV_OFS) begin
            prediv_d = wdata[PREDIV_W-1:0];
         end else if (addr == SRC_OFS) begin
            src_d = wdata[SRC_BIT];
         end else if (addr == RUN_OFS) begin
            run_d = wdata[RUN_BIT];
         end else if (addr == CLOCK_OUT_PIN_OFS) begin
            rate_d = wdata[RATE_LSB +: RATE_W];
            out_en_d = wdata[OUT_EN_BIT];
         end else if (addr == IRQ_STS_OFS) begin
            sts_d = sts_q & ~wdata[EV_W-1:0];
         end else if (addr == IRQ_MASK_OFS) begin
            mask_d = wdata[EV_W-1:0];
         end
      end
      // Hardware set wins over a same-cycle clear
      sts_d = sts_d | ev;
      irq_d = |(sts_d & mask_d);
      rdata_d = DATA_RST;
      if (rd_stb) begin
         if (addr == FBDIV_OFS) begin
            rdata_d[FBDIV_W-1:0] = fbdiv_q;
         end else if (addr == PREDIV_OFS) begin
            rdata_d[PREDIV_W-1:0] = prediv_q;
         end else if (addr == SRC_OFS) begin
            rdata_d[SRC_BIT] = src_q;
         end else if (addr == RUN_OFS) begin
            rdata_d[RUN_BIT] = run_q;
         end else if (addr == LOCK_OFS) begin
            rdata_d[LOCK_BIT] = valid_q;
         end else if (addr == CLOCK_OUT_PIN_OFS) begin
            rdata_d[RATE_LSB +: RATE_W] = rate_q;
            rdata_d[OUT_EN_BIT] = out_en_q;
         end else if (addr == IRQ_STS_OFS) begin
            rdata_d[EV_W-1:0] = sts_q;
         end else if (addr == IRQ_MASK_OFS) begin
            rdata_d[EV_W-1:0] = mask_q;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fbdiv_q <= FBDIV_RST;
         prediv_q <= PREDIV_RST;
         src_q <= 1'b0;
         run_q <= 1'b0;
         run_prev_q <= 1'b0;
         rate_q <= RATE_RST;
         out_en_q <= 1'b0;
         act_fbdiv_q <= FBDIV_RST;
         act_prediv_q <= PREDIV_RST;
         act_src_q <= 1'b0;
         act_rate_q <= RATE_RST;
         act_out_en_q <= 1'b0;
         sts_q <= '0;
         mask_q <= '0;
         irq_q <= 1'b0;
         rdata_q <= DATA_RST;
      end else if (clk_en) begin
         fbdiv_q <= fbdiv_d;
         prediv_q <= prediv_d;
         src_q <= src_d;
         run_q <= run_d;
         run_prev_q <= run_prev_d;
         rate_q <= rate_d;
         out_en_q <= out_en_d;
         act_fbdiv_q <= act_fbdiv_d;
         act_prediv_q <= act_prediv_d;
         act_src_q <= act_src_d;
         act_rate_q <= act_rate_d;
         act_out_en_q <= act_out_en_d;
         sts_q <= sts_d;
         mask_q <= mask_d;
         irq_q <= irq_d;
         rdata_q <= rdata_d;
      end
   end

   // Reference prescaler, period measurement and lock tracking
   always_comb begin
      ref_rise = ref_s2_q & ~ref_s3_q;
      pre_max = 3'((4'h1 << act_prediv_q) - 4'h1);
      pre_tick = 1'b0;
      pre_cnt_d = pre_cnt_q;
      if (state_q == SELC_IDLE) begin
         pre_cnt_d = 3'h0;
      end else if (ref_rise) begin
         if (pre_cnt_q >= pre_max) begin
            pre_cnt_d = 3'h0;
            pre_tick = 1'b1;
         end else begin
            pre_cnt_d = pre_cnt_q + 3'h1;
         end
      end
      // Missing reference edges count as an unstable input
      timeout = (per_cnt_q >= TIMEOUT_C);
      per_cnt_d = per_cnt_q;
      per_d = per_q;
      if (state_q == SELC_IDLE || pre_tick) begin
         per_cnt_d = PER_W'(1);
      end else if (!timeout) begin
         per_cnt_d = per_cnt_q + PER_W'(1);
      end
      if (pre_tick) begin
         per_d = per_cnt_q;
      end
      good_d = good_q;
      state_d = state_q;
      ev = '0;
      case (state_q)
         SELC_IDLE: begin
            good_d = '0;
            // Wait for the commit cycle, so the divider judged is the new one
            if (run_q && run_prev_q && act_fbdiv_q != '0) begin
               state_d = SELC_ACQ;
            end
         end
         SELC_ACQ: begin
            if (!run_q) begin
               state_d = SELC_IDLE;
            end else if (timeout) begin
               good_d = '0;
            end else if (pre_tick) begin
               if (good_q == GOOD_LAST) begin
                  state_d = SELC_LOCKED;
                  ev[EV_LOCK_BIT] = 1'b1;
               end else begin
                  good_d = good_q + GOOD_W'(1);
               end
            end
         end
         SELC_LOCKED: begin
            if (!run_q) begin
               state_d = SELC_IDLE;
               ev[EV_UNLOCK_BIT] = 1'b1;
            end else if (timeout) begin
               state_d = SELC_ACQ;
               good_d = '0;
               ev[EV_UNLOCK_BIT] = 1'b1;
            end
         end
         default: begin
            state_d = SELC_IDLE;
         end
      endcase
      valid_d = (state_d == SELC_LOCKED);
   end

   // Reference is asynchronous: two flops before any logic reads it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_s1_q <= 1'b0;
         ref_s2_q <= 1'b0;
         ref_s3_q <= 1'b0;
         pre_cnt_q <= 3'h0;
         per_cnt_q <= PER_W'(1);
         per_q <= '0;
         good_q <= '0;
         state_q <= SELC_IDLE;
         valid_q <= 1'b0;
      end else if (clk_en) begin
         ref_s1_q <= reference_clock_input;
         ref_s2_q <= ref_s1_q;
         ref_s3_q <= ref_s2_q;
         pre_cnt_q <= pre_cnt_d;
         per_cnt_q <= per_cnt_d;
         per_q <= per_d;
         good_q <= good_d;
         state_q <= state_d;
         valid_q <= valid_d;
      end
   end

   // Output clock: measured predivider period split by the rate code.
   // Resolution is one system clock, so high multiples show jitter.
   always_comb begin
      half = per_q >> ({1'b0, act_rate_q} + 3'h1);
      if (half == '0) begin
         half = PER_W'(1);
      end
      oc_cnt_d = oc_cnt_q;
      out_d = out_q;
      if (state_q != SELC_LOCKED) begin
         oc_cnt_d = '0;
         out_d = 1'b0;
      end else if (oc_cnt_q + PER_W'(1) >= half) begin
         oc_cnt_d = '0;
         out_d = ~out_q;
      end else begin
         oc_cnt_d = oc_cnt_q + PER_W'(1);
      end
      // Same edge as the other active settings, no extra lag on the pin
      oe_d = act_out_en_d;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         oc_cnt_q <= '0;
         out_q <= 1'b0;
         oe_q <= 1'b0;
      end else if (clk_en) begin
         oc_cnt_q <= oc_cnt_d;
         out_q <= out_d;
         oe_q <= oe_d;
      end
   end

   assign rdata = rdata_q;
   assign clock_out_pin = out_q;
   assign clock_out_pin_oe = oe_q;
   assign synth_clk_valid = valid_q;
   assign core_clock_source_sel = act_src_q;
   assign feedback_divider_act = act_fbdiv_q;
   assign prescale_divider_act = act_prediv_q;
   assign irq = irq_q;
endmodule : selc_synth_ctrl

//--- test/selc_ref_src.sv
// Reference source; stall freezes the clock to fake a lost crystal
module selc_ref_src #(
   parameter int HALF_NS = 64
) (
   output logic ref_clk,
   input wire logic stall
);
   timeunit 1ns;
   timeprecision 1ps;
   initial ref_clk = 1'b0;
   always #(HALF_NS) if (!stall) ref_clk = ~ref_clk;
endmodule : selc_ref_src

//--- test/selc_synth_ctrl_monitor.sv
module selc_monitor
   import selc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic clock_out_pin,
   input wire logic clock_out_pin_oe,
   input wire logic synth_clk_valid,
   input wire logic core_clock_source_sel,
   input wire logic [FBDIV_W-1:0] feedback_divider_act,
   input wire logic [PREDIV_W-1:0] prescale_divider_act
);
   logic run_q;
   logic run_d;
   logic [1:0] pend_q;
   logic [1:0] pend_d;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Shadow of software writes, so commits are judged without the body
   always_comb begin
      run_d = run_q;
      pend_d = pend_q;
      if (wr_stb && addr == RUN_OFS) run_d = wdata[RUN_BIT];
      if (wr_stb && addr == CLOCK_OUT_PIN_OFS) pend_d[0] = wdata[OUT_EN_BIT];
      if (wr_stb && addr == SRC_OFS) pend_d[1] = wdata[SRC_BIT];
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         run_q <= 1'b0;
         pend_q <= 2'h0;
      end else begin
         run_q <= run_d;
         pend_q <= pend_d;
      end
   end
   lock_cond_a: assert property (synth_clk_valid |-> $past(run_q) &&
      feedback_divider_act != 7'h0) else $error("lock without run or divider");
   run_stop_a: assert property (wr_stb && addr == RUN_OFS && !wdata[RUN_BIT]
      |-> ##2 !synth_clk_valid) else $error("lock kept after run clear");
   pin_idle_a: assert property (!synth_clk_valid [*2] |-> !clock_out_pin)
      else $error("pin toggles while idle");
   oe_hold_a: assert property ($changed(clock_out_pin_oe)
      |-> $past(run_q) && !$past(run_q, 2)) else $error("pin enable moved");
   cfg_hold_a: assert property ($changed({core_clock_source_sel,
      prescale_divider_act, feedback_divider_act}) |-> $past(run_q) && !$past(run_q, 2))
      else $error("active setting moved");
   commit_copy_a: assert property ($past(run_q) && !$past(run_q, 2)
      |-> clock_out_pin_oe == $past(pend_q[0]) && core_clock_source_sel == $past(pend_q[1]))
      else $error("pending setting not activated");
   lock_read_a: assert property ($past(rd_stb && addr == LOCK_OFS)
      |-> rdata == {15'h0000, $past(synth_clk_valid)}) else $error("lock flag misread");
   rdata_idle_a: assert property (!$past(rd_stb) |-> rdata == DATA_RST)
      else $error("read data outside its cycle");
endmodule : selc_monitor
bind selc_synth_ctrl selc_monitor u_mon (.clk, .rst_b, .addr, .wdata, .wr_stb, .rd_stb,
   .rdata, .clock_out_pin, .clock_out_pin_oe, .synth_clk_valid, .core_clock_source_sel,
   .feedback_divider_act, .prescale_divider_act);

//--- test/tb_synth_enable_lock_clock_out_pin.sv
module tb_synth_enable_lock_clock_out_pin
   import selc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [ADDR_W-1:0] addr = 16'h0000;
   logic [DATA_W-1:0] wdata = 16'h0000;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic stall = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic ref_clk, clock_out_pin, clock_out_pin_oe, synth_clk_valid, core_clock_source_sel, irq;
   logic [FBDIV_W-1:0] feedback_divider_act;
   logic [PREDIV_W-1:0] prescale_divider_act;
   int failures = 0;
   int checked = 0;
   always #2 clk = ~clk;
   selc_synth_ctrl DUT (.clk, .rst_b, .clk_en(1'b1), .addr, .wdata, .wr_stb, .rd_stb, .rdata,
      .reference_clock_input(ref_clk), .clock_out_pin, .clock_out_pin_oe, .synth_clk_valid,
      .core_clock_source_sel, .feedback_divider_act, .prescale_divider_act, .irq);
   // 128 ns reference: a tick of 32 cycles at divide by 1
   selc_ref_src u_ref (.ref_clk, .stall);
   task automatic conclude;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string n, input logic [15:0] e, g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask : wr
   task automatic rc(input logic [15:0] a, e);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      chk("rdata", e, rdata);
   endtask : rc
   task automatic poll;
      int i;
      logic [15:0] v;
      v = 16'h0000;
      for (i = 0; i < 4000 && v[LOCK_BIT] !== 1'b1; i++) begin
         @(posedge clk);
         addr <= LOCK_OFS;
         rd_stb <= 1'b1;
         @(posedge clk);
         rd_stb <= 1'b0;
         @(negedge clk);
         v = rdata;
      end
      chk("lock", 16'h0001, v);
      if (v !== 16'h0001) conclude();
   endtask : poll
   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt
   task automatic t_reset;
      rc(RUN_OFS, 16'h0000);
      rc(LOCK_OFS, 16'h0000);
      rc(CLOCK_OUT_PIN_OFS, 16'h0000);
      rc(FBDIV_OFS, {9'h000, FBDIV_RST});
      rc(16'hf010, 16'h0000);
      $display("reset test done");
   endtask : t_reset
   task automatic t_hold;
      wr(CLOCK_OUT_PIN_OFS, 16'h0001);
      wr(LOCK_OFS, 16'h0001);
      wt(600);
      rc(CLOCK_OUT_PIN_OFS, 16'h0001);
      chk("oe", 16'h0000, clock_out_pin_oe);
      chk("valid", 16'h0000, synth_clk_valid);
      rc(LOCK_OFS, 16'h0000);
      $display("hold test done");
   endtask : t_hold
   task automatic t_rates;
      int n;
      logic p;
      for (int i = 0; i < 4; i++) begin
         wr(PREDIV_OFS, 16'(i));
         wr(SRC_OFS, 16'(i % 2));
         wr(CLOCK_OUT_PIN_OFS, 16'(((3 - i) << RATE_LSB) | 1));
         wr(RUN_OFS, 16'h0001);
         poll();
         chk("src", 16'(i % 2), core_clock_source_sel);
         chk("prediv", 16'(i), prescale_divider_act);
         chk("oe", 16'h0001, clock_out_pin_oe);
         wt(600);
         n = 0;
         p = clock_out_pin;
         repeat (1024) begin
            @(negedge clk);
            if (clock_out_pin && !p) n++;
            p = clock_out_pin;
         end
         chk("rises", 16'(256 >> (2 * i)), 16'(n));
         wr(RUN_OFS, 16'h0000);
         wt(4);
         chk("idle", 16'h0000, synth_clk_valid);
      end
      $display("rate test done");
   endtask : t_rates
   task automatic t_nolock;
      wr(PREDIV_OFS, 16'h0000);
      wr(FBDIV_OFS, 16'h0000);
      wr(CLOCK_OUT_PIN_OFS, 16'h0000);
      wr(RUN_OFS, 16'h0001);
      wt(3000);
      rc(LOCK_OFS, 16'h0000);
      chk("oe", 16'h0000, clock_out_pin_oe);
      chk("fb", 16'h0000, feedback_divider_act);
      wr(RUN_OFS, 16'h0000);
      wr(FBDIV_OFS, 16'h0060);
      $display("no lock test done");
   endtask : t_nolock
   task automatic t_irq;
      wr(IRQ_STS_OFS, 16'h0003);
      wr(IRQ_MASK_OFS, 16'h0001);
      wr(RUN_OFS, 16'h0001);
      poll();
      wt(3);
      chk("irq", 16'h0001, irq);
      wr(IRQ_STS_OFS, 16'h0001);
      wt(3);
      chk("irq", 16'h0000, irq);
      stall <= 1'b1;
      wt(700);
      chk("lost", 16'h0000, synth_clk_valid);
      rc(IRQ_STS_OFS, 16'h0002);
      chk("irq", 16'h0000, irq);
      wr(IRQ_MASK_OFS, 16'h0002);
      wt(3);
      chk("irq", 16'h0001, irq);
      stall <= 1'b0;
      wr(RUN_OFS, 16'h0000);
      $display("interrupt test done");
   endtask : t_irq
   initial begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_hold();
      t_rates();
      t_nolock();
      t_irq();
      conclude();
   end
endmodule : tb_synth_enable_lock_clock_out_pin
